// File: rsr_pkg.sv
package rsr_pkg;
    // ======================================================
    // register map
    localparam logic [7:0] RSR_ADDR_PRIMARY  = 8'h03;
    localparam logic [7:0] RSR_ADDR_FIFO_CNT = 8'h04;
    localparam logic [7:0] RSR_ADDR_AUX      = 8'h05;
    localparam logic [7:0] RSR_ADDR_EV_STAT  = 8'h30;
    localparam logic [7:0] RSR_ADDR_EV_MASK  = 8'h31;

    // ======================================================
    // reset values
    localparam logic [7:0] RSR_PRIMARY_RST = 8'h05;
    localparam logic [6:0] RSR_COUNT_RST   = 7'h00;
    localparam logic [7:0] RSR_AUX_RST     = 8'h60;
    localparam logic [4:0] RSR_EV_RST      = 5'h00;

    // ======================================================
    // field positions
    localparam int RSR_STATE_LSB = 4;
    localparam int RSR_SUM_BIT   = 3;
    localparam int RSR_ERR_BIT   = 2;
    localparam int RSR_HI_BIT    = 1;
    localparam int RSR_LO_BIT    = 0;
    localparam int RSR_TRUN_BIT  = 7;
    localparam int RSR_NVM_BIT   = 6;
    localparam int RSR_CRC_BIT   = 5;

    // event bits of the sticky status register
    localparam int RSR_EV_N     = 5;
    localparam int RSR_EV_HI    = 0;
    localparam int RSR_EV_LO    = 1;
    localparam int RSR_EV_CRC   = 2;
    localparam int RSR_EV_NVM   = 3;
    localparam int RSR_EV_TSTOP = 4;

    localparam logic [6:0] RSR_FIFO_DEPTH = 7'h40;

    // ======================================================
    // types
    typedef enum logic [3:0] {
        RSR_PH_IDLE,
        RSR_PH_SEND_FRAME_START,
        RSR_PH_SEND_PAYLOAD,
        RSR_PH_SEND_FRAME_END,
        RSR_PH_RX_ENTER_TRANSITION,
        RSR_PH_RX_EXIT_TRANSITION,
        RSR_PH_RX_WAIT_PHASE,
        RSR_PH_RX_ARMED,
        RSR_PH_RECEIVING
    } rsr_phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rsr_bus_t;

    typedef struct packed {
        rsr_phase_t phase;
        logic       fifo_push;
        logic       fifo_pop;
        logic [5:0] fifo_threshold;
        logic [7:0] error_flag_reg;
        logic [5:0] request_flags;
        logic [5:0] request_enable_mask;
        logic       timer_active;
        logic       nvm_write_done;
        logic       checksum_done;
        logic [2:0] last_byte_valid_bits;
    } rsr_unit_t;

    typedef struct packed {
        logic [6:0]          count_q;
        logic [7:0]          primary_q;
        logic [7:0]          aux_q;
        logic [7:0]          rd_data_q;
        logic [RSR_EV_N-1:0] ev_stat_q;
        logic [RSR_EV_N-1:0] ev_mask_q;
        logic                irq_q;
    } rsr_state_t;
endpackage : rsr_pkg

// File: rsr_status_regs.sv
`timescale 1ns/1ps
// What this block does
// - state field bits 6:4, idle reads 000
// - sending: 001 start, 010 payload, 011 end
// - both receive transitions read 100
// - receive wait period reads 101
// - armed reads 110, receiving reads 111
// - bit 3 summarises enabled pending requests
// - bit 2 set when any error flag set
// - high alert when free space <= threshold
// - low alert when count <= threshold
// - 7-bit count, write up, read down
// - aux bit 7 shows timer running
// - aux bit 6 high when nvm write done
// - aux bit 5 high when checksum done
// - aux bits 2:0 last byte valid bits
// - reset 05h, 00h, 60h; read-only, reserved zero
// - fifo holds up to 64 bytes
// - request counts only when its enable set
module rsr_status_regs (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire rsr_pkg::rsr_bus_t  bus,
    input  wire rsr_pkg::rsr_unit_t unit,
    output logic [7:0]          rd_data,
    output logic [6:0]          fifo_byte_count,
    output logic                irq
);

    // ======================================================
    // state
    rsr_pkg::rsr_state_t st_q;
    rsr_pkg::rsr_state_t st_d;

    function automatic logic [2:0] rsr_state_code(input rsr_pkg::rsr_phase_t ph);
        logic [2:0] c;
        c = 3'h0;
        unique case (ph)
            rsr_pkg::RSR_PH_IDLE:                c = 3'h0;
            rsr_pkg::RSR_PH_SEND_FRAME_START:    c = 3'h1;
            rsr_pkg::RSR_PH_SEND_PAYLOAD:        c = 3'h2;
            rsr_pkg::RSR_PH_SEND_FRAME_END:      c = 3'h3;
            rsr_pkg::RSR_PH_RX_ENTER_TRANSITION: c = 3'h4;
            rsr_pkg::RSR_PH_RX_EXIT_TRANSITION:  c = 3'h4;
            rsr_pkg::RSR_PH_RX_WAIT_PHASE:       c = 3'h5;
            rsr_pkg::RSR_PH_RX_ARMED:            c = 3'h6;
            rsr_pkg::RSR_PH_RECEIVING:           c = 3'h7;
            default:                             c = 3'h0;
        endcase
        return c;
    endfunction : rsr_state_code

    function automatic logic rsr_hit(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction : rsr_hit

    logic [6:0] thr7;
    logic [6:0] free_space;
    logic       can_push;
    logic       can_pop;
    localparam int RSR_EV_N_W = rsr_pkg::RSR_EV_N;
    logic [RSR_EV_N_W-1:0] ev_set;
    logic [RSR_EV_N_W-1:0] ev_clr;

    // ======================================================
    // next state
    always_comb begin
        st_d       = st_q;
        thr7       = {1'b0, unit.fifo_threshold};
        free_space = rsr_pkg::RSR_FIFO_DEPTH - st_q.count_q;
        // pushes past full and pops past empty are dropped, the count never wraps
        can_push   = unit.fifo_push && (st_q.count_q < rsr_pkg::RSR_FIFO_DEPTH);
        can_pop    = unit.fifo_pop && (st_q.count_q != 7'h00);
        if (can_push && !can_pop) begin
            st_d.count_q = st_q.count_q + 7'h01;
        end else if (can_pop && !can_push) begin
            st_d.count_q = st_q.count_q - 7'h01;
        end

        st_d.primary_q = 8'h00;
        st_d.primary_q[rsr_pkg::RSR_STATE_LSB +: 3] = rsr_state_code(unit.phase);
        st_d.primary_q[rsr_pkg::RSR_SUM_BIT] =
            |(unit.request_flags & unit.request_enable_mask);
        st_d.primary_q[rsr_pkg::RSR_ERR_BIT] = |unit.error_flag_reg;
        st_d.primary_q[rsr_pkg::RSR_HI_BIT]  = free_space <= thr7;
        st_d.primary_q[rsr_pkg::RSR_LO_BIT]  = st_q.count_q <= thr7;

        st_d.aux_q = 8'h00;
        st_d.aux_q[rsr_pkg::RSR_TRUN_BIT] = unit.timer_active;
        st_d.aux_q[rsr_pkg::RSR_NVM_BIT]  = unit.nvm_write_done;
        st_d.aux_q[rsr_pkg::RSR_CRC_BIT]  = unit.checksum_done;
        st_d.aux_q[2:0] = unit.last_byte_valid_bits;

        // events are edges of the registered status, so one edge sets one flag
        ev_set = '0;
        ev_set[rsr_pkg::RSR_EV_HI] = st_d.primary_q[rsr_pkg::RSR_HI_BIT] &
                                     ~st_q.primary_q[rsr_pkg::RSR_HI_BIT];
        ev_set[rsr_pkg::RSR_EV_LO] = st_d.primary_q[rsr_pkg::RSR_LO_BIT] &
                                     ~st_q.primary_q[rsr_pkg::RSR_LO_BIT];
        ev_set[rsr_pkg::RSR_EV_CRC] = st_d.aux_q[rsr_pkg::RSR_CRC_BIT] &
                                      ~st_q.aux_q[rsr_pkg::RSR_CRC_BIT];
        ev_set[rsr_pkg::RSR_EV_NVM] = st_d.aux_q[rsr_pkg::RSR_NVM_BIT] &
                                      ~st_q.aux_q[rsr_pkg::RSR_NVM_BIT];
        ev_set[rsr_pkg::RSR_EV_TSTOP] = ~st_d.aux_q[rsr_pkg::RSR_TRUN_BIT] &
                                        st_q.aux_q[rsr_pkg::RSR_TRUN_BIT];

        ev_clr = '0;
        if (bus.wr && rsr_hit(bus.addr, rsr_pkg::RSR_ADDR_EV_STAT)) begin
            ev_clr = bus.wdata[RSR_EV_N_W-1:0];
        end
        if (bus.wr && rsr_hit(bus.addr, rsr_pkg::RSR_ADDR_EV_MASK)) begin
            st_d.ev_mask_q = bus.wdata[RSR_EV_N_W-1:0];
        end
        // set wins over a clear in the same cycle
        st_d.ev_stat_q = (st_q.ev_stat_q & ~ev_clr) | ev_set;
        st_d.irq_q     = |(st_q.ev_stat_q & st_q.ev_mask_q);

        // primary, count and aux status registers are read-only: writes to them fall on nothing
        st_d.rd_data_q = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                rsr_pkg::RSR_ADDR_PRIMARY:  st_d.rd_data_q = st_q.primary_q;
                rsr_pkg::RSR_ADDR_FIFO_CNT: st_d.rd_data_q = {1'b0, st_q.count_q};
                rsr_pkg::RSR_ADDR_AUX:      st_d.rd_data_q = st_q.aux_q;
                rsr_pkg::RSR_ADDR_EV_STAT:
                    st_d.rd_data_q = {3'h0, st_q.ev_stat_q};
                rsr_pkg::RSR_ADDR_EV_MASK:
                    st_d.rd_data_q = {3'h0, st_q.ev_mask_q};
                default:                    st_d.rd_data_q = 8'h00;
            endcase
        end
    end

    // ======================================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q.count_q   <= rsr_pkg::RSR_COUNT_RST;
            st_q.primary_q <= rsr_pkg::RSR_PRIMARY_RST;
            st_q.aux_q     <= rsr_pkg::RSR_AUX_RST;
            st_q.rd_data_q <= 8'h00;
            st_q.ev_stat_q <= rsr_pkg::RSR_EV_RST;
            st_q.ev_mask_q <= rsr_pkg::RSR_EV_RST;
            st_q.irq_q     <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data         = st_q.rd_data_q;
    assign fifo_byte_count = st_q.count_q;
    assign irq             = st_q.irq_q;

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_state_idle: assert property (
        unit.phase == rsr_pkg::RSR_PH_IDLE |=> st_q.primary_q[6:4] == 3'h0)
        else $error("idle phase not shown as 000");

    a_state_rx_wait: assert property (
        unit.phase == rsr_pkg::RSR_PH_RX_WAIT_PHASE |=> st_q.primary_q[6:4] == 3'h5)
        else $error("receive wait not shown as 101");

    a_summary_bit: assert property (
        ##1 st_q.primary_q[3] ==
            $past(|(unit.request_flags & unit.request_enable_mask)))
        else $error("summary bit does not follow enabled requests");

    a_error_bit: assert property (
        ##1 st_q.primary_q[2] == $past(|unit.error_flag_reg))
        else $error("error bit does not follow error flags");

    a_high_alert: assert property (
        ##1 st_q.primary_q[1] ==
            ((7'h40 - $past(st_q.count_q)) <= {1'b0, $past(unit.fifo_threshold)}))
        else $error("high alert wrong");

    a_low_alert: assert property (
        ##1 st_q.primary_q[0] ==
            ($past(st_q.count_q) <= {1'b0, $past(unit.fifo_threshold)}))
        else $error("low alert wrong");

    a_count_up: assert property (
        unit.fifo_push && !unit.fifo_pop && st_q.count_q < 7'h40
        |=> st_q.count_q == $past(st_q.count_q) + 7'h01)
        else $error("count did not increment");

    a_count_down: assert property (
        unit.fifo_pop && !unit.fifo_push && st_q.count_q != 7'h00
        |=> st_q.count_q == $past(st_q.count_q) - 7'h01)
        else $error("count did not decrement");

    a_count_limit: assert property (
        st_q.count_q <= 7'h40)
        else $error("count above fifo depth");

    a_aux_live: assert property (
        ##1 st_q.aux_q[2:0] == $past(unit.last_byte_valid_bits)
            && st_q.aux_q[4:3] == 2'h0
            && st_q.aux_q[7] == $past(unit.timer_active))
        else $error("aux status does not follow units");

    a_read_answer: assert property (
        bus.rd && bus.addr == 8'h04 |=> rd_data == {1'b0, $past(st_q.count_q)})
        else $error("count read wrong");

    a_read_only: assert property (
        !bus.rd |=> rd_data == 8'h00)
        else $error("read data outside read answer");

    a_set_wins: assert property (
        ev_set[0] && ev_clr[0] |=> st_q.ev_stat_q[0])
        else $error("event lost to clear");

    // ======================================================
    // transceiver phase codes
    a_state_sof: assert property (
        unit.phase == rsr_pkg::RSR_PH_SEND_FRAME_START |=> st_q.primary_q[6:4] == 3'h1)
        else $error("frame start not shown as 001");

    a_state_payload: assert property (
        unit.phase == rsr_pkg::RSR_PH_SEND_PAYLOAD |=> st_q.primary_q[6:4] == 3'h2)
        else $error("payload not shown as 010");

    a_state_eof: assert property (
        unit.phase == rsr_pkg::RSR_PH_SEND_FRAME_END |=> st_q.primary_q[6:4] == 3'h3)
        else $error("frame end not shown as 011");

    a_state_rx_enter: assert property (
        unit.phase == rsr_pkg::RSR_PH_RX_ENTER_TRANSITION |=> st_q.primary_q[6:4] == 3'h4)
        else $error("receive entry not shown as 100");

    a_state_rx_exit: assert property (
        unit.phase == rsr_pkg::RSR_PH_RX_EXIT_TRANSITION |=> st_q.primary_q[6:4] == 3'h4)
        else $error("receive exit not shown as 100");

    a_state_armed: assert property (
        unit.phase == rsr_pkg::RSR_PH_RX_ARMED |=> st_q.primary_q[6:4] == 3'h6)
        else $error("armed not shown as 110");

    a_state_receiving: assert property (
        unit.phase == rsr_pkg::RSR_PH_RECEIVING |=> st_q.primary_q[6:4] == 3'h7)
        else $error("receiving not shown as 111");

    // ======================================================
    // aux unit flags
    a_timer_bit: assert property (
        ##1 st_q.aux_q[7] == $past(unit.timer_active))
        else $error("timer running bit wrong");

    a_nvm_bit: assert property (
        ##1 st_q.aux_q[6] == $past(unit.nvm_write_done))
        else $error("nvm done bit wrong");

    a_crc_bit: assert property (
        ##1 st_q.aux_q[5] == $past(unit.checksum_done))
        else $error("checksum done bit wrong");

    // ======================================================
    // reset values
    // these run through reset, so the common disable is overridden
    a_reset_primary: assert property (
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> st_q.primary_q == rsr_pkg::RSR_PRIMARY_RST)
        else $error("primary status reset value wrong");

    a_reset_count: assert property (
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> st_q.count_q == rsr_pkg::RSR_COUNT_RST)
        else $error("count reset value wrong");

    a_reset_aux: assert property (
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> st_q.aux_q == rsr_pkg::RSR_AUX_RST)
        else $error("aux status reset value wrong");

    // ======================================================
    // read map
    a_read_primary: assert property (
        bus.rd && bus.addr == rsr_pkg::RSR_ADDR_PRIMARY
        |=> rd_data == $past(st_q.primary_q))
        else $error("primary status read wrong");

    a_read_aux: assert property (
        bus.rd && bus.addr == rsr_pkg::RSR_ADDR_AUX
        |=> rd_data == $past(st_q.aux_q))
        else $error("aux status read wrong");

    a_read_unmapped: assert property (
        bus.rd && bus.addr == 8'h10 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");

    a_primary_rsvd: assert property (
        st_q.primary_q[7] == 1'b0)
        else $error("primary reserved bit set");

    // ======================================================
    // byte count limits
    a_count_both: assert property (
        unit.fifo_push && unit.fifo_pop
        |=> $stable(st_q.count_q))
        else $error("count moved on push with pop");

    a_count_full: assert property (
        unit.fifo_push && !unit.fifo_pop && st_q.count_q == 7'h40
        |=> st_q.count_q == 7'h40)
        else $error("count passed fifo depth");

    a_count_empty: assert property (
        unit.fifo_pop && !unit.fifo_push && st_q.count_q == 7'h00
        |=> st_q.count_q == 7'h00)
        else $error("count wrapped below zero");

    a_count_no_bus: assert property (
        bus.wr && bus.addr == 8'h04 && !unit.fifo_push && !unit.fifo_pop
        |=> $stable(st_q.count_q))
        else $error("write changed read-only count");

    // ======================================================
    // watermark corner points, summary and error bit checks
    a_high_example_on: assert property (
        st_q.count_q == 7'h3C && unit.fifo_threshold == 6'h04
        |=> st_q.primary_q[1])
        else $error("high alert missing at 60 of 4");

    a_high_example_off: assert property (
        st_q.count_q == 7'h3B && unit.fifo_threshold == 6'h04
        |=> !st_q.primary_q[1])
        else $error("high alert set at 59 of 4");

    a_low_example_on: assert property (
        st_q.count_q == 7'h04 && unit.fifo_threshold == 6'h04
        |=> st_q.primary_q[0])
        else $error("low alert missing at 4 of 4");

    a_low_example_off: assert property (
        st_q.count_q == 7'h05 && unit.fifo_threshold == 6'h04
        |=> !st_q.primary_q[0])
        else $error("low alert set at 5 of 4");

    a_sum_masked: assert property (
        (unit.request_flags & unit.request_enable_mask) == 6'h00 |=> !st_q.primary_q[3])
        else $error("summary set with no enabled request");

    a_err_clear: assert property (
        unit.error_flag_reg == 8'h00 |=> !st_q.primary_q[2])
        else $error("error bit set with no error flag");

    // ======================================================
    // event flags and interrupt
    a_irq_level: assert property (
        ##1 irq ==
            $past(|(st_q.ev_stat_q & st_q.ev_mask_q)))
        else $error("interrupt does not follow flags");

    a_mask_write: assert property (
        bus.wr && bus.addr == rsr_pkg::RSR_ADDR_EV_MASK
        |=> st_q.ev_mask_q == $past(bus.wdata[RSR_EV_N_W-1:0]))
        else $error("mask write lost");

    a_irq_off: assert property (
        st_q.ev_mask_q == '0 |=> !irq)
        else $error("interrupt with all events masked");

    // a flag stays until software writes a one over it
    for (genvar i = 0; i < RSR_EV_N_W; i++) begin : g_ev_sticky
        a_ev_sticky: assert property (
            st_q.ev_stat_q[i] && !ev_clr[i] |=> st_q.ev_stat_q[i])
            else $error("event flag dropped without a clear");
    end

    // every detected edge must leave its flag behind
    for (genvar j = 0; j < RSR_EV_N_W; j++) begin : g_ev_catch
        a_ev_catch: assert property (
            ev_set[j] |=> st_q.ev_stat_q[j])
            else $error("event edge not recorded");
    end

endmodule : rsr_status_regs

// File: rsr_status_regs_bench.sv
`timescale 1ns/1ps
module rsr_status_regs_bench;
    logic               clk;
    logic               sys_rst;
    rsr_pkg::rsr_bus_t  bus;
    rsr_pkg::rsr_unit_t unit;
    logic [7:0]         rd_data;
    logic [6:0]         fifo_byte_count;
    logic               irq;
    int                 err_count;
    int                 comparisons;
    logic [7:0]         d;
    logic [2:0]         codes [0:8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h6, 3'h7};

    rsr_status_regs uut (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .bus             (bus),
        .unit            (unit),
        .rd_data         (rd_data),
        .fifo_byte_count (fifo_byte_count),
        .irq             (irq)
    );

    // ======================================================
    // clock, reset and watchdog
    always #2.5 clk = ~clk;

    task report_and_stop;
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // hang guard: the whole sequence needs well under this many cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // ======================================================
    // bus and compare helpers
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        d = rd_data;
        chk(d, exp);
        @(posedge clk);
    endtask : rdchk

    task wr(input logic [7:0] a, input logic [7:0] v);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    // status inputs show in a read two edges after they change
    task settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task pulse(input int n, input logic up);
        repeat (n) begin
            unit.fifo_push <= up;
            unit.fifo_pop  <= ~up;
            @(posedge clk);
            unit.fifo_push <= 1'b0;
            unit.fifo_pop  <= 1'b0;
            @(posedge clk);
        end
    endtask : pulse

    // ======================================================
    // scenarios
    task t_reset;
        // live inputs chosen so live values equal the reset values
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h05);
        rdchk(rsr_pkg::RSR_ADDR_FIFO_CNT, 8'h00);
        rdchk(rsr_pkg::RSR_ADDR_AUX, 8'h60);
        rdchk(8'h10, 8'h00);
    endtask : t_reset

    task t_phase;
        for (int i = 0; i < 9; i++) begin
            unit.phase <= rsr_pkg::rsr_phase_t'(4'(i));
            settle();
            rdchk(rsr_pkg::RSR_ADDR_PRIMARY, {1'b0, codes[i], 4'h5});
        end
        unit.phase <= rsr_pkg::RSR_PH_IDLE;
    endtask : t_phase

    task t_flags;
        unit.request_flags <= 6'h20;
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h05);
        unit.request_enable_mask <= 6'h20;
        unit.error_flag_reg      <= 8'h00;
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h09);
        unit.request_flags  <= 6'h00;
        unit.error_flag_reg <= 8'h80;
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h05);
    endtask : t_flags

    task t_count;
        unit.fifo_threshold <= 6'h04;
        pulse(4, 1'b1);
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h05);
        pulse(1, 1'b1);
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h04);
        pulse(54, 1'b1);
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h04);
        pulse(1, 1'b1);
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h06);
        pulse(5, 1'b1);
        settle();
        chk({1'b0, fifo_byte_count}, 8'h40);
        wr(rsr_pkg::RSR_ADDR_FIFO_CNT, 8'hFF);
        rdchk(rsr_pkg::RSR_ADDR_FIFO_CNT, 8'h40);
        rdchk(rsr_pkg::RSR_ADDR_FIFO_CNT, 8'h40);
        pulse(65, 1'b0);
        settle();
        rdchk(rsr_pkg::RSR_ADDR_FIFO_CNT, 8'h00);
        unit.fifo_threshold <= 6'h3F;
        settle();
        rdchk(rsr_pkg::RSR_ADDR_PRIMARY, 8'h05);
    endtask : t_count

    task t_aux_irq;
        unit.timer_active         <= 1'b1;
        unit.nvm_write_done       <= 1'b0;
        unit.checksum_done        <= 1'b0;
        unit.last_byte_valid_bits <= 3'h5;
        settle();
        wr(rsr_pkg::RSR_ADDR_AUX, 8'h00);
        rdchk(rsr_pkg::RSR_ADDR_AUX, 8'h85);
        wr(rsr_pkg::RSR_ADDR_EV_STAT, 8'h1F);
        wr(rsr_pkg::RSR_ADDR_EV_MASK, 8'h00);
        unit.checksum_done <= 1'b1;
        settle();
        rdchk(rsr_pkg::RSR_ADDR_EV_STAT, 8'h04);
        chk({7'h00, irq}, 8'h00);
        wr(rsr_pkg::RSR_ADDR_EV_MASK, 8'h04);
        settle();
        chk({7'h00, irq}, 8'h01);
        rdchk(rsr_pkg::RSR_ADDR_EV_MASK, 8'h04);
        wr(rsr_pkg::RSR_ADDR_EV_STAT, 8'h04);
        settle();
        chk({7'h00, irq}, 8'h00);
        rdchk(rsr_pkg::RSR_ADDR_AUX, 8'hA5);
    endtask : t_aux_irq

    // ======================================================
    // main sequence
    initial begin
        clk         = 1'b0;
        sys_rst     = 1'b1;
        err_count   = 0;
        comparisons = 0;
        bus         = '0;
        unit        = '0;
        unit.phase          = rsr_pkg::RSR_PH_IDLE;
        unit.error_flag_reg = 8'h01;
        unit.nvm_write_done = 1'b1;
        unit.checksum_done  = 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_phase();
        t_flags();
        t_count();
        t_aux_irq();
        report_and_stop();
    end
endmodule : rsr_status_regs_bench
